// >>> hdl/pcsk_pkg.sv
/*
  constants and carrier types for the 16-bit card socket control block.
  assumes one 20 MHz clock and a synchronous active-high reset.
*/
// Functional notes
// - io write cycles pull the io write strobe low.
// - memory read cycles pull output enable low.
// - ready/request line means ready only in memory-only mode.
// - attribute select stays high for every common memory access.
// - attribute select with oe or we reaches attribute memory only.
// - attribute select with io strobes reaches io space.
// - socket drives a card reset output forcing hard card reset.
// - wait asserted by the card stretches the cycle; never end early.
// - memory writes are strobed with write enable.
// - for io cards the protect line means wide io port.
// - both voltage-sense lines are decoded together.
// - io read cycles assert the io read strobe.
// - even_byte_enable for even bytes, odd_byte_enable for odd bytes.
package pcsk_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  // strobe setup, active and hold times in nanoseconds
  localparam int unsigned SETUP_NS = 100;
  localparam int unsigned STROBE_NS = 300;
  localparam int unsigned HOLD_NS = 50;
  localparam int unsigned SETUP_CYC = (SETUP_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned STROBE_CYC = (STROBE_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned HOLD_CYC = (HOLD_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [CNT_W-1:0] SETUP_LD = CNT_W'(SETUP_CYC);
  localparam logic [CNT_W-1:0] STROBE_LD = CNT_W'(STROBE_CYC);
  localparam logic [CNT_W-1:0] HOLD_LD = CNT_W'(HOLD_CYC);
  localparam int unsigned ADDR_W = 26;
  localparam int unsigned DATA_W = 16;

  typedef enum logic [1:0] {
    PCSK_CMD_MEM_RD,
    PCSK_CMD_MEM_WR,
    PCSK_CMD_IO_RD,
    PCSK_CMD_IO_WR
  } pcsk_cmd_e;

  typedef enum logic [1:0] {
    PCSK_VOLT_5V,
    PCSK_VOLT_3V3,
    PCSK_VOLT_XV,
    PCSK_VOLT_YV
  } pcsk_volt_e;

  typedef struct packed {
    pcsk_cmd_e cmd;
    logic attr;
    logic wide;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } pcsk_req_s;

  typedef struct packed {
    logic oe_n;
    logic we_n;
    logic io_read_strobe_n;
    logic io_write_strobe_n;
    logic reg_n;
    logic even_n;
    logic odd_n;
  } pcsk_strobe_s;

  localparam pcsk_strobe_s STROBE_IDLE = 7'h7f;
endpackage

// >>> hdl/pcsk_sync.sv
/*
  three-stage pin synchroniser; a change is taken once stages two and three agree.
  assumes an asynchronous pin and the block clock.
*/
`timescale 1ns/1ns
module pcsk_sync #(
  parameter logic RST_VAL = 1'b1
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic pin_i,
  output logic level_o
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
      s3_reg <= RST_VAL;
      level_o <= RST_VAL;
    end else begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        level_o <= s3_reg;
      end
    end
  end
endmodule

// >>> hdl/pcsk_socket.sv
/*
  16-bit card socket control: strobe sequencing, wait stretch, status decode.
  assumes a host request port on the same clock; card pins are asynchronous.
*/
`timescale 1ns/1ns
module pcsk_socket (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic io_mode_i,
  input wire logic card_reset_req_i,
  input wire logic req_valid_i,
  input wire pcsk_pkg::pcsk_req_s req_i,
  output logic req_ready_o,
  output logic done_o,
  output logic [pcsk_pkg::DATA_W-1:0] rdata_o,
  output logic rd_ack_o,
  output pcsk_pkg::pcsk_strobe_s strobe_o,
  output logic [pcsk_pkg::ADDR_W-1:0] addr_o,
  output logic [pcsk_pkg::DATA_W-1:0] data_o,
  output logic [pcsk_pkg::DATA_W-1:0] data_oe_n_o,
  input wire logic [pcsk_pkg::DATA_W-1:0] data_i,
  output logic card_reset_o,
  input wire logic ready_req_n_i,
  input wire logic wait_n_i,
  input wire logic protect_wide_i,
  input wire logic input_ack_line_n_i,
  input wire logic voltage_sense_first_i,
  input wire logic voltage_sense_second_i,
  output logic voltage_sense_first_o,
  output logic voltage_sense_first_oe_n_o,
  output logic voltage_sense_second_o,
  output logic voltage_sense_second_oe_n_o,
  output logic card_busy_o,
  output logic card_service_request_o,
  output logic write_protect_o,
  output logic io_port_wide_indication_o,
  output pcsk_pkg::pcsk_volt_e volt_o
);
  import pcsk_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_WAIT, ST_HOLD} pcsk_state_e;

  pcsk_state_e state_reg;
  pcsk_req_s cur_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic rdy_s;
  logic wait_s;
  logic prot_s;
  logic ack_s;
  logic vs1_s;
  logic vs2_s;
  logic is_read;
  logic strobe_on;

  pcsk_sync u_sync_rdy (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .pin_i(ready_req_n_i), .level_o(rdy_s));
  pcsk_sync u_sync_wait (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .pin_i(wait_n_i), .level_o(wait_s));
  pcsk_sync u_sync_prot (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .pin_i(protect_wide_i), .level_o(prot_s));
  pcsk_sync u_sync_ack (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .pin_i(input_ack_line_n_i), .level_o(ack_s));
  pcsk_sync u_sync_vs1 (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .pin_i(voltage_sense_first_i), .level_o(vs1_s));
  pcsk_sync u_sync_vs2 (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .pin_i(voltage_sense_second_i), .level_o(vs2_s));

  assign is_read = (cur_reg.cmd == PCSK_CMD_MEM_RD) || (cur_reg.cmd == PCSK_CMD_IO_RD);
  assign strobe_on = (state_reg == ST_STROBE) || (state_reg == ST_WAIT);
  // no new cycle while the card is held in reset
  assign req_ready_o = (state_reg == ST_IDLE) && !card_reset_o;

  // cycle sequencer
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      state_reg <= ST_IDLE;
      cnt_reg <= CNT_ZERO;
      cur_reg <= '0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (req_valid_i && req_ready_o) begin
            cur_reg <= req_i;
            cnt_reg <= SETUP_LD;
            state_reg <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          if (cnt_reg <= CNT_ONE) begin
            cnt_reg <= STROBE_LD;
            state_reg <= ST_STROBE;
          end else begin
            cnt_reg <= cnt_reg - CNT_ONE;
          end
        end
        ST_STROBE: begin
          if (cnt_reg <= CNT_ONE) begin
            state_reg <= ST_WAIT;
          end else begin
            cnt_reg <= cnt_reg - CNT_ONE;
          end
        end
        ST_WAIT: begin
          // stretched while the card asserts wait
          if (wait_s) begin
            cnt_reg <= HOLD_LD;
            state_reg <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          if (cnt_reg <= CNT_ONE) begin
            state_reg <= ST_IDLE;
          end else begin
            cnt_reg <= cnt_reg - CNT_ONE;
          end
        end
      endcase
    end
  end

  // command strobes, one-hot by command so read and write never overlap
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      strobe_o <= STROBE_IDLE;
    end else begin
      strobe_o <= STROBE_IDLE;
      if (state_reg != ST_IDLE) begin
        // common memory keeps attribute select high; io cycles use it low
        strobe_o.reg_n <= !(cur_reg.attr || cur_reg.cmd == PCSK_CMD_IO_RD ||
          cur_reg.cmd == PCSK_CMD_IO_WR);
        strobe_o.even_n <= !(cur_reg.wide || !cur_reg.addr[0]);
        strobe_o.odd_n <= !(cur_reg.wide || cur_reg.addr[0]);
      end
      if ((state_reg == ST_SETUP && cnt_reg <= CNT_ONE) ||
          (strobe_on && !(state_reg == ST_WAIT && wait_s))) begin
        unique case (cur_reg.cmd)
          PCSK_CMD_MEM_RD: strobe_o.oe_n <= 1'b0;
          PCSK_CMD_MEM_WR: strobe_o.we_n <= 1'b0;
          PCSK_CMD_IO_RD: strobe_o.io_read_strobe_n <= 1'b0;
          PCSK_CMD_IO_WR: strobe_o.io_write_strobe_n <= 1'b0;
        endcase
      end
    end
  end

  // address and write data launch
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      addr_o <= '0;
      data_o <= '0;
      data_oe_n_o <= '1;
    end else begin
      if (req_valid_i && req_ready_o) begin
        addr_o <= req_i.addr;
        data_o <= req_i.wdata;
      end
      if (state_reg != ST_IDLE && !is_read) begin
        data_oe_n_o <= '0;
      end else begin
        data_oe_n_o <= '1;
      end
    end
  end

  // read capture and completion
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rdata_o <= '0;
      done_o <= 1'b0;
      rd_ack_o <= 1'b0;
    end else begin
      done_o <= (state_reg == ST_HOLD) && (cnt_reg <= CNT_ONE);
      if (state_reg == ST_WAIT && wait_s && is_read) begin
        rdata_o <= data_i;
        // acknowledge only meaningful on io reads
        rd_ack_o <= (cur_reg.cmd == PCSK_CMD_IO_RD) && !ack_s;
      end
    end
  end

  // card reset
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      card_reset_o <= 1'b1;
    end else begin
      card_reset_o <= card_reset_req_i;
    end
  end

  // status decode from shared card lines
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      card_busy_o <= 1'b0;
      card_service_request_o <= 1'b0;
      write_protect_o <= 1'b0;
      io_port_wide_indication_o <= 1'b0;
      volt_o <= PCSK_VOLT_5V;
    end else begin
      card_busy_o <= !io_mode_i && !rdy_s;
      card_service_request_o <= io_mode_i && !rdy_s;
      write_protect_o <= !io_mode_i && prot_s;
      // wide-port flag is only valid during an io cycle
      io_port_wide_indication_o <= io_mode_i && !prot_s && (state_reg != ST_IDLE);
      volt_o <= pcsk_volt_e'({vs2_s, vs1_s});
    end
  end

  // sense lines are only read here, never driven
  assign voltage_sense_first_o = 1'b0;
  assign voltage_sense_first_oe_n_o = 1'b1;
  assign voltage_sense_second_o = 1'b0;
  assign voltage_sense_second_oe_n_o = 1'b1;

  a_no_rw_overlap: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    !((!strobe_o.oe_n || !strobe_o.io_read_strobe_n) && (!strobe_o.we_n || !strobe_o.io_write_strobe_n)))
    else $error("read and write strobes together");
  a_common_reg_high: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (!strobe_o.oe_n || !strobe_o.we_n) && !cur_reg.attr |-> strobe_o.reg_n)
    else $error("attribute select low on common access");
  a_io_reg_low: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    (!strobe_o.io_read_strobe_n || !strobe_o.io_write_strobe_n) |-> !strobe_o.reg_n)
    else $error("io strobe without attribute select");
  a_wait_holds_strobe: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    state_reg == ST_WAIT && !wait_s |=> state_reg == ST_WAIT)
    else $error("cycle ended during wait");
  a_io_write_strobe_low: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    state_reg == ST_STROBE && cur_reg.cmd == PCSK_CMD_IO_WR |-> !strobe_o.io_write_strobe_n)
    else $error("io write strobe not low");
  a_oe_low: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    state_reg == ST_STROBE && cur_reg.cmd == PCSK_CMD_MEM_RD |-> !strobe_o.oe_n)
    else $error("output enable not low");
  a_io_read_strobe_low: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    state_reg == ST_STROBE && cur_reg.cmd == PCSK_CMD_IO_RD |-> !strobe_o.io_read_strobe_n)
    else $error("io read strobe not low");
  a_we_low: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    state_reg == ST_STROBE && cur_reg.cmd == PCSK_CMD_MEM_WR |-> !strobe_o.we_n)
    else $error("write enable not low");
  a_card_reset: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    card_reset_req_i |=> card_reset_o)
    else $error("card reset not asserted");
  a_busy_mode: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    io_mode_i |=> !card_busy_o)
    else $error("busy reported in io mode");
  a_service_mode: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    !io_mode_i |=> !card_service_request_o)
    else $error("service request in memory mode");
  // first edge after reset still shows the reset code, so it is skipped
  a_volt_pair: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    !$past(sys_rst_i) |-> volt_o == pcsk_volt_e'({$past(vs2_s), $past(vs1_s)}))
    else $error("voltage decode mismatch");
  a_byte_lane: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
    state_reg != ST_IDLE && !cur_reg.wide && cur_reg.addr[0] && strobe_on |-> strobe_o.even_n)
    else $error("even enable on odd byte");

  c_mem_read: cover property (@(posedge ref_clk_i) !strobe_o.oe_n ##[1:20] done_o);
  c_io_write: cover property (@(posedge ref_clk_i) !strobe_o.io_write_strobe_n ##[1:20] done_o);
  c_wait_stretch: cover property (@(posedge ref_clk_i) state_reg == ST_WAIT && !wait_s);
  c_service: cover property (@(posedge ref_clk_i) card_service_request_o);
endmodule

// >>> tb/pcsk_card_model.sv
/*
  behavioural 16-bit card on the far side of the socket: read data, busy, request, wait.
  assumes the socket strobes and address as registered outputs on the same clock.
*/
`timescale 1ns/1ns
module pcsk_card_model (
  input wire logic ref_clk_i,
  input wire logic io_mode_i,
  input wire pcsk_pkg::pcsk_strobe_s strobe_i,
  input wire logic [pcsk_pkg::ADDR_W-1:0] addr_i,
  input wire logic irq_i,
  input wire logic wp_i,
  input wire logic [3:0] wait_cyc_i,
  input wire logic [1:0] vcode_i,
  output logic [pcsk_pkg::DATA_W-1:0] data_o,
  output logic ready_req_n_o,
  output logic wait_n_o,
  output logic protect_wide_o,
  output logic ack_n_o,
  output logic vs1_o,
  output logic vs2_o
);
  import pcsk_pkg::*;
  logic [4:0] busy_cnt = 5'h00;
  logic [3:0] wait_cnt = 4'h0;
  logic cmd_low_d = 1'b0;
  logic cmd_low;
  logic decoded;
  initial data_o = 16'h0000;
  assign cmd_low = !(strobe_i.oe_n && strobe_i.we_n && strobe_i.io_read_strobe_n && strobe_i.io_write_strobe_n);
  // only the low 64k of io space answers
  assign decoded = addr_i[25:16] == 10'h000;
  assign {vs2_o, vs1_o} = vcode_i;
  always @(posedge ref_clk_i) begin
    cmd_low_d <= cmd_low;
    if (!strobe_i.we_n && !io_mode_i) busy_cnt <= 5'h14;
    else if (busy_cnt != 5'h00) busy_cnt <= busy_cnt - 5'h01;
    if (cmd_low && !cmd_low_d) wait_cnt <= wait_cyc_i;
    else if (wait_cnt != 4'h0) wait_cnt <= wait_cnt - 4'h1;
    // released bus toggles so a late sample never looks right by luck
    if (!strobe_i.oe_n || !strobe_i.io_read_strobe_n) data_o <= addr_i[15:0] ^ 16'hc35a;
    else data_o <= ~data_o;
  end
  assign ready_req_n_o = io_mode_i ? !irq_i : (busy_cnt == 5'h00);
  assign wait_n_o = (wait_cnt == 4'h0);
  assign protect_wide_o = io_mode_i ? !decoded : wp_i;
  assign ack_n_o = !(io_mode_i && !strobe_i.io_read_strobe_n && decoded);
endmodule

// >>> tb/tb_top.sv
/*
  self-checking bench for the socket control block with a card model on its pins.
  assumes the design package and the card model are compiled first.
*/
`timescale 1ns/1ns
module tb_top;
  import pcsk_pkg::*;
  typedef struct packed {
    pcsk_cmd_e cmd;
    logic attr;
    logic wide;
    logic [25:0] addr;
    logic [6:0] exp;
  } pcsk_row_s;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic io_mode = 1'b0;
  logic rst_req = 1'b0;
  logic req_valid = 1'b0;
  logic irq = 1'b0;
  logic wp = 1'b0;
  logic [3:0] wait_cyc = 4'h0;
  logic [1:0] vcode = 2'h0;
  pcsk_req_s req = '0;
  logic req_ready, done, rd_ack, card_reset, ready_n, wait_n, pw, ack_n, vs1, vs2;
  logic busy, srv, wpo, rdy_s;
  logic wide_ind;
  logic wide_seen = 1'b0;
  logic [DATA_W-1:0] rdata, data, data_oe_n, data_i;
  logic [ADDR_W-1:0] addr;
  pcsk_strobe_s strobe;
  pcsk_volt_e volt;
  logic [6:0] acc;
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int lowcnt = 0;
  pcsk_row_s rows[6] = '{
    '{PCSK_CMD_MEM_RD, 1'b0, 1'b0, 26'h00a40, 7'h3d},
    '{PCSK_CMD_MEM_WR, 1'b0, 1'b1, 26'h00a40, 7'h5c},
    '{PCSK_CMD_MEM_RD, 1'b1, 1'b0, 26'h00a41, 7'h3a},
    '{PCSK_CMD_MEM_WR, 1'b1, 1'b0, 26'h00a41, 7'h5a},
    '{PCSK_CMD_IO_RD, 1'b0, 1'b1, 26'h00a40, 7'h68},
    '{PCSK_CMD_IO_WR, 1'b0, 1'b0, 26'h00a41, 7'h72}};

  pcsk_socket u_pcsk_socket (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .io_mode_i(io_mode),
    .card_reset_req_i(rst_req), .req_valid_i(req_valid), .req_i(req), .req_ready_o(req_ready),
    .done_o(done), .rdata_o(rdata), .rd_ack_o(rd_ack), .strobe_o(strobe), .addr_o(addr),
    .data_o(data), .data_oe_n_o(data_oe_n), .data_i(data_i), .card_reset_o(card_reset),
    .ready_req_n_i(ready_n), .wait_n_i(wait_n), .protect_wide_i(pw), .input_ack_line_n_i(ack_n),
    .voltage_sense_first_i(vs1), .voltage_sense_second_i(vs2), .voltage_sense_first_o(),
    .voltage_sense_first_oe_n_o(), .voltage_sense_second_o(), .voltage_sense_second_oe_n_o(),
    .card_busy_o(busy), .card_service_request_o(srv), .write_protect_o(wpo),
    .io_port_wide_indication_o(wide_ind), .volt_o(volt));
  pcsk_card_model u_pcsk_card_model (.ref_clk_i(ref_clk_i), .io_mode_i(io_mode),
    .strobe_i(strobe), .addr_i(addr), .irq_i(irq), .wp_i(wp), .wait_cyc_i(wait_cyc),
    .vcode_i(vcode), .data_o(data_i), .ready_req_n_o(ready_n), .wait_n_o(wait_n),
    .protect_wide_o(pw), .ack_n_o(ack_n), .vs1_o(vs1), .vs2_o(vs2));

  initial forever #25 ref_clk_i = ~ref_clk_i;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic wt(input int n);
    repeat (n) @(negedge ref_clk_i);
    @(posedge ref_clk_i);
  endtask

  // strobes settle by mid-cycle, so the monitor samples on the falling edge
  always @(negedge ref_clk_i) begin
    rdy_s = req_ready;
    acc = acc & strobe;
    if (wide_ind === 1'b1) wide_seen = 1'b1;
    if (!(strobe.oe_n && strobe.we_n && strobe.io_read_strobe_n && strobe.io_write_strobe_n)) lowcnt++;
    if ((!strobe.oe_n || !strobe.io_read_strobe_n) && (!strobe.we_n || !strobe.io_write_strobe_n)) chk(1, 0);
  end

  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      end_of_test();
    end
  end

  task automatic run(input pcsk_cmd_e c, input logic at, input logic wd, input logic [25:0] a);
    int n;
    req <= '{cmd: c, attr: at, wide: wd, addr: a, wdata: a[15:0] ^ 16'h1e3c};
    io_mode <= c[1];
    req_valid <= 1'b1;
    n = 0;
    do @(posedge ref_clk_i); while (!rdy_s && ++n < 100);
    req_valid <= 1'b0;
    acc = 7'h7f;
    wide_seen = 1'b0;
    lowcnt = 0;
    @(negedge ref_clk_i);
    chk(req_ready, 0);
    n = 0;
    while (done !== 1'b1 && n < 200) begin
      @(negedge ref_clk_i);
      n++;
    end
    chk(n < 200, 1);
  endtask

  initial begin
    repeat (8) @(posedge ref_clk_i);
    chk(strobe, STROBE_IDLE);
    chk(card_reset, 1);
    sys_rst_i <= 1'b0;
    wt(6);
    for (int i = 0; i < 6; i++) begin
      run(rows[i].cmd, rows[i].attr, rows[i].wide, rows[i].addr);
      chk(acc, rows[i].exp);
      if (!rows[i].cmd[0]) chk(rdata, rows[i].addr[15:0] ^ 16'hc35a);
      else chk(data, rows[i].addr[15:0] ^ 16'h1e3c);
      if (rows[i].cmd == PCSK_CMD_IO_RD) chk(rd_ack, 1);
      chk(wide_seen, rows[i].cmd[1]);
      $display("row %0d finished", i);
      @(posedge ref_clk_i);
    end
    wait_cyc <= 4'hc;
    run(PCSK_CMD_MEM_RD, 1'b0, 1'b0, 26'h00040);
    chk(lowcnt > 12, 1);
    wait_cyc <= 4'h0;
    $display("wait stretch finished");
    wt(30);
    run(PCSK_CMD_MEM_WR, 1'b0, 1'b0, 26'h00010);
    wt(6);
    chk(busy, 1);
    chk(srv, 0);
    wt(30);
    chk(busy, 0);
    io_mode <= 1'b1;
    irq <= 1'b1;
    wt(8);
    chk(srv, 1);
    chk(busy, 0);
    irq <= 1'b0;
    wt(8);
    chk(srv, 0);
    io_mode <= 1'b0;
    wp <= 1'b1;
    wt(8);
    chk(wpo, 1);
    wp <= 1'b0;
    wt(8);
    chk(wpo, 0);
    $display("status lines finished");
    for (int v = 0; v < 4; v++) begin
      vcode <= v[1:0];
      wt(8);
      chk(volt, v);
    end
    rst_req <= 1'b1;
    wt(2);
    chk(card_reset, 1);
    chk(req_ready, 0);
    rst_req <= 1'b0;
    wt(2);
    chk(card_reset, 0);
    sys_rst_i <= 1'b1;
    wt(4);
    chk(card_reset, 1);
    chk(strobe, STROBE_IDLE);
    sys_rst_i <= 1'b0;
    wt(2);
    chk(card_reset, 0);
    chk(req_ready, 1);
    $display("sense and reset finished");
    end_of_test();
  end
endmodule
